// File: include/atcu_pkg.sv
// Purpose: Shared constants and types for the asynchronous timer compare unit
// Assumes: Byte-wide registers, one per aligned 32-bit word
// Notes: Offsets are byte addresses on the register bus
package atcu_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_MASK  = 8'h70;
  localparam logic [7:0] ADDR_FLAG  = 8'h74;
  localparam logic [7:0] ADDR_CTRL  = 8'hb0;
  localparam logic [7:0] ADDR_CNT   = 8'hb4;
  localparam logic [7:0] ADDR_CMP   = 8'hb8;
  localparam logic [7:0] ADDR_ASR   = 8'hbc;
  // Control register fields
  localparam int CTRL_FORCE  = 7;
  localparam int CTRL_WGM0   = 6;
  localparam int CTRL_COM_HI = 5;
  localparam int CTRL_COM_LO = 4;
  localparam int CTRL_WGM1   = 3;
  // Async status fields
  localparam int ASR_EXT_CLOCK_INPUT_ENABLE   = 4;
  localparam int ASR_ASYNC   = 3;
  localparam int UB_CNT      = 2;
  localparam int UB_CMP      = 1;
  localparam int UB_CTRL     = 0;
  // Mask and flag fields
  localparam int BIT_CMP     = 1;
  localparam int BIT_OVF     = 0;
  // Values
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] TOP_MAX    = 8'hff;
  localparam logic [7:0] BOTTOM     = 8'h00;
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int PRESCALE_W = 10;
  // Waveform modes
  typedef enum logic [1:0] {
    WG_NORMAL = 2'b00,
    WG_PHASE  = 2'b01,
    WG_CTC    = 2'b10,
    WG_FAST   = 2'b11
  } atcu_wgm_t;
  // Compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'b00;
  localparam logic [1:0] COM_TOGGLE = 2'b01;
  localparam logic [1:0] COM_CLEAR  = 2'b10;
  localparam logic [1:0] COM_SET    = 2'b11;
  // Divider mask per clock select code
  function automatic logic [9:0] atcu_div_mask(input logic [2:0] cs);
    unique case (cs)
      3'h2:    atcu_div_mask = 10'h007;
      3'h3:    atcu_div_mask = 10'h01f;
      3'h4:    atcu_div_mask = 10'h03f;
      3'h5:    atcu_div_mask = 10'h07f;
      3'h6:    atcu_div_mask = 10'h0ff;
      3'h7:    atcu_div_mask = 10'h3ff;
      default: atcu_div_mask = 10'h000;
    endcase
  endfunction
endpackage

// File: rtl/atcu_prescaler.sv
// Purpose: Divider chain turning source ticks into timer ticks
// Assumes: src_tick is a one-cycle enable on clk
// Notes: Divider free-runs; a select change may give one short period
`timescale 1ns/1ps
module atcu_prescaler
  import atcu_pkg::*;
#(
  parameter int PRE_W = PRESCALE_W
) (
  input  logic       clk,      // System clock
  input  logic       rst_b,    // Async reset, active low
  input  logic       src_tick, // Source clock enable
  input  logic [2:0] cs,       // Clock select field
  output logic       tick      // Timer clock enable
);
  typedef struct packed {
    logic [PRE_W-1:0] cnt;
  } atcu_pre_t;

  atcu_pre_t        q;
  atcu_pre_t        d;
  logic [PRE_W-1:0] msk;

  // Tick when the selected low bits are all ones
  always_comb begin
    d   = q;
    msk = PRE_W'(atcu_div_mask(cs));
    if (src_tick) d.cnt = q.cnt + 1'b1;
    tick = src_tick && (cs != CS_STOP) && ((q.cnt & msk) == msk);
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) q <= '0;
    else q <= d;
  end

  a_stop_no_tick: assert property (@(posedge clk) disable iff (!rst_b)
    (cs == CS_STOP) |-> !tick) else $error("tick while clock stopped");
endmodule // atcu_prescaler

// File: rtl/atcu_top.sv
// Purpose: Byte timer with one compare channel behind an AXI4-Lite slave
// Assumes: TIMER_OSC_IN is synchronous to CLK_SYS and far slower than it
// Notes: Oscillator edges act as one-cycle enables; no second clock domain
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module atcu_top
  import atcu_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  logic              CLK_SYS,       // System clock, 40 MHz
  input  logic              RST_B,         // Async reset, active low
  input  logic [ADDR_W-1:0] S_AXI_AWADDR,  // Write address
  input  logic              S_AXI_AWVALID, // Write address valid
  output logic              S_AXI_AWREADY, // Write address ready
  input  logic [31:0]       S_AXI_WDATA,   // Write data
  input  logic [3:0]        S_AXI_WSTRB,   // Write byte enables
  input  logic              S_AXI_WVALID,  // Write data valid
  output logic              S_AXI_WREADY,  // Write data ready
  output logic [1:0]        S_AXI_BRESP,   // Write response
  output logic              S_AXI_BVALID,  // Write response valid
  input  logic              S_AXI_BREADY,  // Write response ready
  input  logic [ADDR_W-1:0] S_AXI_ARADDR,  // Read address
  input  logic              S_AXI_ARVALID, // Read address valid
  output logic              S_AXI_ARREADY, // Read address ready
  output logic [31:0]       S_AXI_RDATA,   // Read data
  output logic [1:0]        S_AXI_RRESP,   // Read response
  output logic              S_AXI_RVALID,  // Read data valid
  input  logic              S_AXI_RREADY,  // Read data ready
  input  logic              TIMER_OSC_IN,  // Oscillator or external clock
  input  logic              GLOBAL_IE,     // CPU global interrupt enable
  input  logic              CMP_VEC_ACK,   // Compare vector executed
  input  logic              OVF_VEC_ACK,   // Overflow vector executed
  output logic              CMP_IRQ,       // Compare interrupt request
  output logic              OVF_IRQ,       // Overflow interrupt request
  input  logic              PIN_DIR,       // Port direction bit of pin
  input  logic              PORT_DATA,     // Ordinary port output value
  output logic              PIN_O,         // Pin output value
  output logic              PIN_OE,        // Pin output enable
  output logic              OC_OVERRIDE,   // Waveform owns the pin
  output logic              XTAL_EN,       // Crystal oscillator enable
  output logic              EXT_CLK_EN     // External clock buffer enable
);
  typedef struct packed {
    logic              aw_v;
    logic [ADDR_W-1:0] aw_a;
    logic              w_v;
    logic [7:0]        w_d;
    logic              w_s;
    logic              b_v;
    logic [1:0]        b_r;
    logic              r_v;
    logic [7:0]        r_d;
    logic [1:0]        r_r;
    logic [1:0]        mask;
    logic [1:0]        flags;
    logic [7:0]        ctrl_tmp;
    logic [7:0]        ctrl_act;
    logic              force_p;
    logic [7:0]        cnt;
    logic [7:0]        cnt_tmp;
    logic [7:0]        cmp_tmp;
    logic [7:0]        cmp_act;
    logic [7:0]        cmp_use;
    logic [2:0]        busy;
    logic              async_sel;
    logic              ext_clock_input_enable;
    logic              down;
    logic              oc;
    logic              blk;
    logic              osc_prev;
  } atcu_state_t;

  atcu_state_t q;
  atcu_state_t d;
  atcu_wgm_t   wgm;
  logic [1:0]  com;
  logic        pwm;
  logic        src_tick;
  logic        tick;
  logic        match;
  logic        set_cmp;
  logic        set_ovf;
  logic        top_act;
  logic        wr_fire;
  logic        rd_fire;
  logic        wr_ctrl;
  logic        wr_cnt;
  logic        wr_cmp;
  logic [7:0]  wd;
  logic [1:0]  clr;

  // Output value that a match produces in the current mode
  function automatic logic match_level(input atcu_wgm_t m, input logic [1:0] c,
                                       input logic dn, input logic cur);
    match_level = cur;
    if (m == WG_PHASE) begin
      if (c[1]) match_level = c[0] ^ dn;
    end else if (m == WG_FAST) begin
      if (c[1]) match_level = c[0];
    end else begin
      unique case (c)
        COM_TOGGLE: match_level = ~cur;
        COM_CLEAR:  match_level = 1'b0;
        COM_SET:    match_level = 1'b1;
        default:    match_level = cur;
      endcase
    end
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
    hit = (a[7:2] == r[7:2]);
  endfunction

  // Divider for the timer clock
  atcu_prescaler #(
    .PRE_W (PRESCALE_W)
  ) u_pre (
    .clk      (CLK_SYS),
    .rst_b    (RST_B),
    .src_tick (src_tick),
    .cs       (q.ctrl_act[2:0]),
    .tick     (tick)
  );

  // Next state: bus, transfers, counting, waveform, flags
  always_comb begin
    d        = q;
    d.osc_prev = TIMER_OSC_IN;
    src_tick = q.async_sel ? (TIMER_OSC_IN & ~q.osc_prev) : 1'b1;
    wgm      = atcu_wgm_t'({q.ctrl_act[CTRL_WGM1], q.ctrl_act[CTRL_WGM0]});
    com      = q.ctrl_act[CTRL_COM_HI:CTRL_COM_LO];
    pwm      = (wgm == WG_PHASE) || (wgm == WG_FAST);
    match    = (q.cnt == q.cmp_use);
    set_cmp  = 1'b0;
    set_ovf  = 1'b0;
    top_act  = 1'b0;
    clr      = 2'b00;
    wd       = q.w_d;
    // Bus handshakes; a write runs once address and data are both held
    if (S_AXI_AWVALID && !q.aw_v) begin
      d.aw_v = 1'b1;
      d.aw_a = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !q.w_v) begin
      d.w_v = 1'b1;
      d.w_d = S_AXI_WDATA[7:0];
      d.w_s = S_AXI_WSTRB[0];
    end
    wr_fire = q.aw_v && q.w_v && !q.b_v;
    rd_fire = S_AXI_ARVALID && !q.r_v;
    if (q.b_v && S_AXI_BREADY) d.b_v = 1'b0;
    if (q.r_v && S_AXI_RREADY) d.r_v = 1'b0;
    if (wr_fire) begin
      d.aw_v = 1'b0;
      d.w_v  = 1'b0;
      d.b_v  = 1'b1;
      d.b_r  = RESP_SLVERR;
      if (hit(q.aw_a, ADDR_MASK) || hit(q.aw_a, ADDR_FLAG) || hit(q.aw_a, ADDR_CTRL) ||
          hit(q.aw_a, ADDR_CNT) || hit(q.aw_a, ADDR_CMP) || hit(q.aw_a, ADDR_ASR))
        d.b_r = RESP_OKAY;
    end
    wr_ctrl = wr_fire && q.w_s && hit(q.aw_a, ADDR_CTRL);
    wr_cnt  = wr_fire && q.w_s && hit(q.aw_a, ADDR_CNT);
    wr_cmp  = wr_fire && q.w_s && hit(q.aw_a, ADDR_CMP);
    // Read path; live count, temporaries for compare and control
    if (rd_fire) begin
      d.r_v = 1'b1;
      d.r_r = RESP_OKAY;
      d.r_d = RST_BYTE;
      if (hit(S_AXI_ARADDR, ADDR_CNT)) d.r_d = q.cnt;
      else if (hit(S_AXI_ARADDR, ADDR_CMP)) d.r_d = q.cmp_tmp;
      else if (hit(S_AXI_ARADDR, ADDR_CTRL)) d.r_d = {1'b0, q.ctrl_tmp[6:0]};
      else if (hit(S_AXI_ARADDR, ADDR_MASK)) d.r_d = {6'h00, q.mask};
      else if (hit(S_AXI_ARADDR, ADDR_FLAG)) d.r_d = {6'h00, q.flags};
      else if (hit(S_AXI_ARADDR, ADDR_ASR)) d.r_d = {3'h0, q.ext_clock_input_enable, q.async_sel, q.busy};
      else d.r_r = RESP_SLVERR;
    end
    // Forced compare acts on the pin only, never on flags or count
    if (q.force_p) begin
      d.force_p = 1'b0;
      if (!pwm) d.oc = match_level(wgm, com, q.down, q.oc);
    end
    // Timer tick: match first, then count
    if (tick) begin
      d.blk = 1'b0;
      if (match && !q.blk) begin
        set_cmp = 1'b1;
        if (!(pwm && q.cmp_use == TOP_MAX && com[1]))
          d.oc = match_level(wgm, com, q.down, q.oc);
      end
      unique case (wgm)
        WG_NORMAL: begin
          d.cnt   = q.cnt + 8'h01;
          set_ovf = (q.cnt == TOP_MAX);
        end
        WG_CTC: begin
          d.cnt   = match ? BOTTOM : q.cnt + 8'h01;
          set_ovf = (q.cnt == TOP_MAX);
        end
        WG_FAST: begin
          d.cnt = q.cnt + 8'h01;
          if (q.cnt == TOP_MAX) begin
            set_ovf   = 1'b1;
            top_act   = com[1];
            d.cmp_use = q.cmp_act;
          end
        end
        WG_PHASE: begin
          if (!q.down) begin
            if (q.cnt == TOP_MAX) begin
              d.down    = 1'b1;
              d.cnt     = q.cnt - 8'h01;
              top_act   = com[1] && (q.cmp_use == TOP_MAX);
              d.cmp_use = q.cmp_act;
            end else d.cnt = q.cnt + 8'h01;
          end else if (q.cnt == BOTTOM) begin
            d.down  = 1'b0;
            d.cnt   = q.cnt + 8'h01;
            set_ovf = 1'b1;
          end else d.cnt = q.cnt - 8'h01;
        end
      endcase
      if (top_act) d.oc = ~com[0];
    end
    if (!pwm) d.down = 1'b0;
    // Handshake: temporaries land on an oscillator edge, and busy drops in the same cycle
    if (q.async_sel && src_tick) begin
      if (q.busy[UB_CNT]) begin
        d.cnt = q.cnt_tmp;
        d.blk = 1'b1;
      end
      if (q.busy[UB_CMP]) d.cmp_act = q.cmp_tmp;
      if (q.busy[UB_CTRL]) begin
        d.ctrl_act = {1'b0, q.ctrl_tmp[6:0]};
        d.force_p  = q.ctrl_tmp[CTRL_FORCE];
      end
      d.busy = 3'h0;
    end
    // Register writes
    if (wr_ctrl) begin
      d.ctrl_tmp = wd;
      if (q.async_sel) d.busy[UB_CTRL] = 1'b1;
      else begin
        d.ctrl_act = {1'b0, wd[6:0]};
        d.force_p  = wd[CTRL_FORCE];
      end
    end
    if (wr_cnt) begin
      d.cnt_tmp = wd;
      if (q.async_sel) d.busy[UB_CNT] = 1'b1;
      else begin
        d.cnt = wd;
        d.blk = 1'b1;
      end
    end
    if (wr_cmp) begin
      d.cmp_tmp = wd;
      if (q.async_sel) d.busy[UB_CMP] = 1'b1;
      else d.cmp_act = wd;
    end
    if (wr_fire && q.w_s && hit(q.aw_a, ADDR_MASK)) d.mask = wd[1:0];
    if (wr_fire && q.w_s && hit(q.aw_a, ADDR_FLAG)) clr = wd[1:0];
    if (wr_fire && q.w_s && hit(q.aw_a, ADDR_ASR)) begin
      d.ext_clock_input_enable     = wd[ASR_EXT_CLOCK_INPUT_ENABLE];
      d.async_sel = wd[ASR_ASYNC];
      if (wd[ASR_ASYNC] != q.async_sel) d.busy = 3'h0;
    end
    // Compare value follows at once outside PWM, at top inside
    if (!pwm) d.cmp_use = d.cmp_act;
    // Flags: a set in the cycle of a clear still wins
    d.flags[BIT_CMP] = (q.flags[BIT_CMP] & ~clr[BIT_CMP] & ~CMP_VEC_ACK) | set_cmp;
    d.flags[BIT_OVF] = (q.flags[BIT_OVF] & ~clr[BIT_OVF] & ~OVF_VEC_ACK) | set_ovf;
  end

  // State register
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) q <= '0;
    else q <= d;
  end

  // Bus outputs
  assign S_AXI_AWREADY = !q.aw_v;
  assign S_AXI_WREADY  = !q.w_v;
  assign S_AXI_BVALID  = q.b_v;
  assign S_AXI_BRESP   = q.b_r;
  assign S_AXI_ARREADY = !q.r_v;
  assign S_AXI_RVALID  = q.r_v;
  assign S_AXI_RRESP   = q.r_r;
  assign S_AXI_RDATA   = {24'h000000, q.r_d};

  // Requests gated by mask and the CPU global enable
  assign CMP_IRQ = GLOBAL_IE & q.mask[BIT_CMP] & q.flags[BIT_CMP];
  assign OVF_IRQ = GLOBAL_IE & q.mask[BIT_OVF] & q.flags[BIT_OVF];

  // Pin mux; the direction bit still gates the driver
  assign OC_OVERRIDE = |q.ctrl_act[CTRL_COM_HI:CTRL_COM_LO];
  assign PIN_O       = OC_OVERRIDE ? q.oc : PORT_DATA;
  assign PIN_OE      = PIN_DIR;

  // Crystal runs only while the external clock bit is low
  assign XTAL_EN    = q.async_sel & ~q.ext_clock_input_enable;
  assign EXT_CLK_EN = q.async_sel & q.ext_clock_input_enable;

  // Checks
  a_cmp_irq_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    CMP_IRQ |-> GLOBAL_IE && q.mask[BIT_CMP] && q.flags[BIT_CMP]) else $error("compare request ungated");
  a_ovf_irq_gate: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (GLOBAL_IE && q.mask[BIT_OVF] && q.flags[BIT_OVF]) |-> OVF_IRQ) else $error("overflow request missing");
  a_pin_released: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (q.ctrl_act[CTRL_COM_HI:CTRL_COM_LO] == COM_OFF) |-> PIN_O == PORT_DATA) else $error("pin not released");
  a_match_flag: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (tick && match && !q.blk) |=> q.flags[BIT_CMP]) else $error("match did not set flag");
  a_write_blocks: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (wr_cnt && !q.async_sel) |=> !set_cmp) else $error("match after counter write");
  a_cnt_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (wr_cnt && q.async_sel) |=> q.busy[UB_CNT] && q.cnt_tmp == $past(q.w_d)) else $error("counter busy not set");
  a_cmp_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (wr_cmp && q.async_sel && !src_tick) |=> q.busy[UB_CMP] && $stable(q.cmp_act)) else $error("compare busy");
  a_ctrl_xfer: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (q.busy[UB_CTRL] && q.async_sel && src_tick && !wr_ctrl) |=> !q.busy[UB_CTRL] &&
    q.ctrl_act[6:0] == q.ctrl_tmp[6:0]) else $error("control transfer failed");
  a_phase_bottom: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (set_ovf && wgm == WG_PHASE) |-> q.cnt == BOTTOM && q.down) else $error("phase overflow off bottom");
  a_fast_top: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (tick && wgm == WG_FAST && q.cnt == TOP_MAX && com == COM_CLEAR) |=> q.oc) else $error("top did not set");
  a_flag_clear: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (clr[BIT_CMP] && !set_cmp) |=> !q.flags[BIT_CMP]) else $error("flag not cleared");
  a_read_live: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
    (rd_fire && hit(S_AXI_ARADDR, ADDR_CNT)) |=> S_AXI_RDATA[7:0] == $past(q.cnt)) else $error("count read");
  c_phase_turn: cover property (@(posedge CLK_SYS) disable iff (!RST_B) set_ovf && wgm == WG_PHASE);
  c_async_xfer: cover property (@(posedge CLK_SYS) disable iff (!RST_B) q.busy[UB_CNT] ##1 !q.busy[UB_CNT]);
  c_cmp_irq: cover property (@(posedge CLK_SYS) disable iff (!RST_B) $rose(CMP_IRQ));
endmodule // atcu_top

// File: verification/atcu_top_tb_top.sv
// Purpose: Self-checking bench for the timer compare unit over its register bus
// Assumes: Slave answers within a few cycles; timer stopped and idle after reset
// Notes: Duty and divided-count checks allow a few cycles of prescaler phase slack
`timescale 1ns/1ps
module atcu_top_tb_top;
  import atcu_pkg::*;
  logic        clk = 0, rst_b = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic        osc = 0, gie = 0, cack = 0, oack = 0, pdir = 0, pdat = 0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat, rd_w;
  logic [1:0]  brsp, rrsp, bresp, rresp;
  logic        awr, wrr, bv, arr, rv, cirq, oirq, po, poe, ovr, xen, een;
  int          n_fail = 0, num_checks = 0, cyc = 0;

  atcu_top uut (
    .CLK_SYS(clk), .RST_B(rst_b), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrr), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd_w), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .TIMER_OSC_IN(osc),
    .GLOBAL_IE(gie), .CMP_VEC_ACK(cack), .OVF_VEC_ACK(oack), .CMP_IRQ(cirq), .OVF_IRQ(oirq),
    .PIN_DIR(pdir), .PORT_DATA(pdat), .PIN_O(po), .PIN_OE(poe), .OC_OVERRIDE(ovr), .XTAL_EN(xen),
    .EXT_CLK_EN(een));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  // Hang guard; the whole run needs about 70k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  // Ready is judged at the falling edge, so the release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    tb = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1;
    wv <= 1;
    bre <= 1;
    while (!tb) begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wrr;
      tb = bv;
      brsp = bresp;
      @(posedge clk);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end
    bre <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    tr = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1;
    rre <= 1;
    while (!tr) begin
      @(negedge clk);
      ta = arv & arr;
      tr = rv;
      rdat = rd_w;
      rrsp = rresp;
      @(posedge clk);
      if (ta) arv <= 0;
    end
    rre <= 0;
  endtask

  // One oscillator period; the line stands low otherwise
  task automatic osc_tick;
    @(posedge clk);
    osc <= 1;
    repeat (4) @(posedge clk);
    osc <= 0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_regs;
    rd(ADDR_MASK);
    chk(rdat, 32'h0, "mask reset");
    rd(8'h00);
    chk({30'h0, rrsp}, {30'h0, RESP_SLVERR}, "unmapped read");
    wr(8'h04, 8'h00);
    chk({30'h0, brsp}, {30'h0, RESP_SLVERR}, "unmapped write");
    wr(ADDR_MASK, 8'hff);
    rd(ADDR_MASK);
    chk(rdat, 32'h3, "mask bits");
    pdat <= 1;
    pdir <= 1;
    @(negedge clk);
    chk({30'h0, po, poe}, 32'h3, "port pin");
    wr(ADDR_CNT, 8'h5a);
    repeat (20) @(posedge clk);
    rd(ADDR_CNT);
    chk(rdat, 32'h5a, "stopped count");
  endtask

  task automatic t_match;
    logic b;
    gie <= 1;
    wr(ADDR_CMP, 8'h40);
    wr(ADDR_CTRL, 8'h11);
    @(negedge clk);
    chk({31'h0, ovr}, 32'h1, "override");
    b = po;
    for (int i = 0; i < 300 && cirq !== 1'b1; i++) @(negedge clk);
    chk({31'h0, cirq}, 32'h1, "compare irq");
    repeat (2) @(negedge clk);
    chk({31'h0, po}, {31'h0, ~b}, "toggle");
    rd(ADDR_FLAG);
    chk(rdat & 32'h2, 32'h2, "compare flag");
    wr(ADDR_FLAG, 8'h02);
    rd(ADDR_FLAG);
    chk(rdat & 32'h2, 32'h0, "compare clear");
    oack <= 1;
    @(posedge clk);
    oack <= 0;
    @(negedge clk);
    chk({31'h0, oirq}, 32'h0, "overflow ack");
    for (int i = 0; i < 300 && oirq !== 1'b1; i++) @(negedge clk);
    chk({31'h0, oirq}, 32'h1, "overflow irq");
    for (int i = 0; i < 300 && cirq !== 1'b1; i++) @(negedge clk);
    chk({31'h0, cirq}, 32'h1, "compare irq again");
    @(posedge clk);
    cack <= 1;
    @(posedge clk);
    cack <= 0;
    @(negedge clk);
    chk({31'h0, cirq}, 32'h0, "compare ack");
    @(posedge clk);
    gie <= 0;
    @(negedge clk);
    chk({30'h0, cirq, oirq}, 32'h0, "global off");
  endtask

  // Compare stays 0x40; count pin-high cycles over 1024 cycles
  task automatic t_pwm;
    logic [7:0] cb[4] = '{8'h69, 8'h79, 8'h61, 8'h71};
    int ex[4] = '{260, 764, 258, 766};
    int h;
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CTRL, cb[m]);
      repeat (600) @(posedge clk);
      h = 0;
      repeat (1024) begin
        @(negedge clk);
        h += po;
      end
      chk({31'h0, h >= ex[m] - 8 && h <= ex[m] + 8}, 32'h1, "duty");
    end
  endtask

  // Clear on match keeps the count at or under compare; force acts on the pin alone
  task automatic t_ctc;
    logic b;
    wr(ADDR_CTRL, 8'h19);
    wr(ADDR_CNT, 8'h00);
    repeat (4) begin
      repeat (37) @(posedge clk);
      rd(ADDR_CNT);
      chk({31'h0, rdat <= 32'h40}, 32'h1, "clear on match");
    end
    wr(ADDR_CTRL, 8'h18);
    @(negedge clk);
    b = po;
    wr(ADDR_CTRL, 8'h98);
    @(negedge clk);
    chk({31'h0, po}, {31'h0, ~b}, "forced toggle");
    rd(ADDR_CTRL);
    chk(rdat, 32'h18, "force reads zero");
  endtask

  // Forty timer ticks per select code, plus bus overhead on the undivided one
  task automatic t_presc;
    int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    for (int i = 1; i < 8; i++) begin
      wr(ADDR_CTRL, 8'h00);
      wr(ADDR_CNT, 8'h00);
      wr(ADDR_CTRL, 8'(i));
      repeat (dv[i] * 40) @(posedge clk);
      wr(ADDR_CTRL, 8'h00);
      rd(ADDR_CNT);
      chk({31'h0, rdat >= 39 && rdat <= 45}, 32'h1, "divided count");
    end
  endtask

  task automatic t_async;
    wr(ADDR_ASR, 8'h08);
    @(negedge clk);
    chk({30'h0, xen, een}, 32'h2, "crystal on");
    wr(ADDR_CNT, 8'h33);
    wr(ADDR_CMP, 8'h77);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_ASR);
    chk(rdat, 32'h0f, "busy set");
    rd(ADDR_CMP);
    chk(rdat, 32'h77, "compare temp");
    osc_tick();
    rd(ADDR_ASR);
    chk(rdat, 32'h08, "busy clear");
    rd(ADDR_CNT);
    chk(rdat, 32'h33, "async count");
    wr(ADDR_ASR, 8'h18);
    @(negedge clk);
    chk({30'h0, xen, een}, 32'h1, "external clock");
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1;
    t_regs();
    t_match();
    t_pwm();
    t_ctc();
    t_presc();
    t_async();
    results();
  end
endmodule // atcu_top_tb_top
